// file: pkg/ur_pkg.sv
package ur_pkg;
  // register offsets from the port base
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER = 3'h1;
  localparam logic [2:0] OFF_FCR = 3'h2;
  localparam logic [2:0] OFF_LCR = 3'h3;
  localparam logic [2:0] OFF_MCR = 3'h4;
  localparam logic [2:0] OFF_LSR = 3'h5;
  localparam logic [2:0] OFF_MSR = 3'h6;
  localparam logic [2:0] OFF_SCR = 3'h7;
  // field positions
  localparam int DIVISOR_ACCESS_SELECT_BIT = 7;
  localparam int STOP2_BIT = 2;
  localparam int PAR_EN_BIT = 3;
  localparam int PAR_EVEN_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXCLR_BIT = 1;
  localparam int FCR_TXCLR_BIT = 2;
  // values after reset
  localparam logic [15:0] DIVISOR_RST = 16'h000C;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] SCR_RST = 8'h00;
  // receive trigger levels in characters
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
  // timing: baud = base rate / divisor, sampled at 16x
  localparam int CLK_HZ = 100_000_000;
  localparam int BASE_BAUD = 115200;
  localparam int OVERSAMPLE = 16;
  localparam int ACC_W = 27;
  localparam logic [ACC_W-1:0] REF_STEP = ACC_W'(BASE_BAUD * OVERSAMPLE);
  localparam logic [ACC_W-1:0] CLK_STEP = ACC_W'(CLK_HZ);
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [3:0] FULL_BIT = 4'hF;
  // buffering
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ur_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ur_rx_e;

  // one received character with its line errors
  typedef struct packed {
    logic brk;
    logic frameErr;
    logic parErr;
    logic [7:0] data;
  } ur_rxchar_s;
endpackage : ur_pkg

// file: design/ur_uart.sv
// Overview of operation
// RULE1: line config bit 7 selects divisor access
// RULE2: offset 0 read pops oldest received char
// RULE3: offset 0 write queues char for sending
// RULE4: selector set: offsets 0/1 reach divisor
// RULE5: baud equals 115200 over the divisor
// RULE6: offset 1 bits 0-3 enable interrupt sources
// RULE7: fifo control enables, flushes receive, flushes transmit
// RULE8: bits 7:6 pick trigger 1/4/8/14
// RULE9: line config bits 1:0 give 5-8 bits
// RULE10: modem control bit0 DTR, bit1 RTS
// RULE11: status bits 0-4: ready, overrun, parity, framing, break
// RULE12: status bit5 holding empty, bit6 shifter empty
// RULE13: status bit7 while errored char in fifo
// RULE14: modem status 0-3 record input changes
// RULE15: modem status 4-7 show input levels
// RULE16: offset 7 scratch byte reads back
// RULE17: eight-bit registers at offsets from base
// RULE18: host places ports at 3F8h and 2F8h
// RULE19: start bit, data lsb first, stop bits
// RULE20: status reads clear change and error flags
`timescale 1ns/1ns

module ur_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic push;
  logic pop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule : ur_fifo

module ur_uart (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdata,
  output logic irq,
  output logic txd,
  input wire logic rxd,
  input wire logic ctsN,
  input wire logic dsrN,
  input wire logic riN,
  input wire logic dcdN,
  output logic dtrN,
  output logic rtsN
);
  localparam int CW = ur_pkg::CNT_W;
  logic [7:0] line_control, ier, modem_control, scratch;
  logic [15:0] divisor;
  logic fifoEn;
  logic [1:0] trigSel;
  logic divisor_access_select;
  logic [4:0] syncA, syncB;
  logic rxS;
  logic [3:0] msrLvl, msrPrev, msrDelta, next_msrDelta;
  logic [3:0] lsrFlags, newFlags;
  logic [ur_pkg::ACC_W-1:0] acc;
  logic refTick, baudTick;
  logic [15:0] divCnt, divLimit;
  logic txInValid, txInReady, txOutValid, txPop;
  logic [7:0] txOutData;
  logic [CW-1:0] txCount, rxCount, errCnt;
  logic rxPush, rxAccept, rxInReady, rxOutValid, rxPop, rxFlush, txFlush;
  ur_pkg::ur_rxchar_s rxEntry, rxHead;
  ur_pkg::ur_tx_e txState;
  ur_pkg::ur_rx_e rxState;
  logic [7:0] txShift, rxShift, wordMask, rxData;
  logic [2:0] txBit, rxBit;
  logic [3:0] txTick, rxTick;
  logic txPar, rxParBit, txStop2;
  logic [4:0] trigLevel;
  logic rxHit, thrEmpty, tsrEmpty, wrData, rdData, rdLsr, rdMsr;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  assign divisor_access_select = line_control[ur_pkg::DIVISOR_ACCESS_SELECT_BIT]; // RULE1
  assign wrData = wrEn && addr == ur_pkg::OFF_DATA && !divisor_access_select;
  assign rdData = rdEn && addr == ur_pkg::OFF_DATA && !divisor_access_select;
  assign rdLsr = rdEn && addr == ur_pkg::OFF_LSR;
  assign rdMsr = rdEn && addr == ur_pkg::OFF_MSR;
  assign wordMask = 8'hFF >> (2'd3 - line_control[1:0]); // RULE9

  // pins from the far side pass two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA <= 5'h1F;
      syncB <= 5'h1F;
    end else begin
      syncA <= {dcdN, riN, dsrN, ctsN, rxd};
      syncB <= syncA;
    end
  end
  assign rxS = syncB[0];
  assign msrLvl = ~syncB[4:1];

  // writable registers; divisor shares offsets 0/1 with data and enables
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_control <= ur_pkg::LCR_RST;
      ier <= ur_pkg::IER_RST;
      modem_control <= ur_pkg::MCR_RST;
      scratch <= ur_pkg::SCR_RST;
      divisor <= ur_pkg::DIVISOR_RST;
      fifoEn <= 1'b0;
      trigSel <= 2'b00;
    end else if (wrEn) begin
      unique case (addr)
        ur_pkg::OFF_DATA: if (divisor_access_select) divisor[7:0] <= wdata; // RULE4
        ur_pkg::OFF_IER: begin
          if (divisor_access_select) divisor[15:8] <= wdata; // RULE4
          else ier <= {4'h0, wdata[3:0]}; // RULE6
        end
        ur_pkg::OFF_FCR: begin
          fifoEn <= wdata[ur_pkg::FCR_EN_BIT]; // RULE7
          trigSel <= wdata[7:6]; // RULE8
        end
        ur_pkg::OFF_LCR: line_control <= wdata;
        ur_pkg::OFF_MCR: modem_control <= {6'h00, wdata[1:0]};
        ur_pkg::OFF_SCR: scratch <= wdata; // RULE16
        default: ;
      endcase
    end
  end

  // a change of fifo mode also empties both queues
  assign rxFlush = wrEn && addr == ur_pkg::OFF_FCR
    && (wdata[ur_pkg::FCR_RXCLR_BIT] || wdata[ur_pkg::FCR_EN_BIT] != fifoEn); // RULE7
  assign txFlush = wrEn && addr == ur_pkg::OFF_FCR
    && (wdata[ur_pkg::FCR_TXCLR_BIT] || wdata[ur_pkg::FCR_EN_BIT] != fifoEn); // RULE7

  // modem outputs are active low on the pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dtrN <= 1'b1;
      rtsN <= 1'b1;
    end else begin
      dtrN <= ~modem_control[0]; // RULE10
      rtsN <= ~modem_control[1]; // RULE10
    end
  end

  // 16x reference at base rate by phase accumulator, then divisor
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= '0;
      refTick <= 1'b0;
    end else if (acc + ur_pkg::REF_STEP >= ur_pkg::CLK_STEP) begin
      acc <= acc + ur_pkg::REF_STEP - ur_pkg::CLK_STEP;
      refTick <= 1'b1;
    end else begin
      acc <= acc + ur_pkg::REF_STEP;
      refTick <= 1'b0;
    end
  end
  // a zero divisor runs as one rather than stopping the line
  assign divLimit = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= '0;
    end else if (refTick) begin
      divCnt <= (divCnt >= divLimit) ? 16'h0000 : divCnt + 16'h0001; // RULE5
    end
  end
  assign baudTick = refTick && divCnt >= divLimit; // RULE5

  // without fifos each queue holds a single character
  assign txInValid = wrData && (fifoEn ? txInReady : txCount == '0); // RULE3
  ur_fifo #(.WIDTH(8), .DEPTH(ur_pkg::FIFO_DEPTH)) txFifo (
    .clk(clk), .rstn(rstn), .flush(txFlush),
    .inValid(txInValid), .inReady(txInReady), .inData(wdata),
    .outValid(txOutValid), .outReady(txState == ur_pkg::TX_IDLE),
    .outData(txOutData), .count(txCount)
  );
  assign txPop = txOutValid && txState == ur_pkg::TX_IDLE;

  // transmitter stalls the fifo until the previous frame ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txState <= ur_pkg::TX_IDLE;
      txd <= 1'b1;
      txShift <= 8'h00;
      txBit <= 3'h0;
      txTick <= 4'h0;
      txPar <= 1'b0;
      txStop2 <= 1'b0;
    end else begin
      if (baudTick) txTick <= txTick + 4'h1;
      unique case (txState)
        ur_pkg::TX_IDLE: if (txPop) begin
          txState <= ur_pkg::TX_START;
          txd <= 1'b0; // RULE19
          txShift <= txOutData & wordMask;
          txPar <= (^(txOutData & wordMask)) ^ ~line_control[ur_pkg::PAR_EVEN_BIT];
          txTick <= 4'h0;
          txBit <= 3'h0;
          txStop2 <= 1'b0;
        end
        ur_pkg::TX_START: if (baudTick && txTick == ur_pkg::FULL_BIT) begin
          txState <= ur_pkg::TX_DATA;
          txd <= txShift[0]; // RULE19
        end
        ur_pkg::TX_DATA: if (baudTick && txTick == ur_pkg::FULL_BIT) begin
          if (txBit == {1'b1, line_control[1:0]}) begin
            txState <= line_control[ur_pkg::PAR_EN_BIT] ? ur_pkg::TX_PARITY : ur_pkg::TX_STOP;
            txd <= line_control[ur_pkg::PAR_EN_BIT] ? txPar : 1'b1;
          end else begin
            txd <= txShift[1];
            txShift <= txShift >> 1;
            txBit <= txBit + 3'h1;
          end
        end
        ur_pkg::TX_PARITY: if (baudTick && txTick == ur_pkg::FULL_BIT) begin
          txState <= ur_pkg::TX_STOP;
          txd <= 1'b1; // RULE19
        end
        ur_pkg::TX_STOP: if (baudTick && txTick == ur_pkg::FULL_BIT) begin
          if (line_control[ur_pkg::STOP2_BIT] && !txStop2) txStop2 <= 1'b1;
          else txState <= ur_pkg::TX_IDLE;
        end
      endcase
    end
  end
  assign thrEmpty = (txCount == '0); // RULE12
  assign tsrEmpty = thrEmpty && txState == ur_pkg::TX_IDLE; // RULE12

  // receiver: confirm start at mid bit, then sample each bit centre
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxState <= ur_pkg::RX_IDLE;
      rxShift <= 8'h00;
      rxBit <= 3'h0;
      rxTick <= 4'h0;
      rxParBit <= 1'b0;
      rxPush <= 1'b0;
    end else begin
      rxPush <= 1'b0;
      if (baudTick) rxTick <= rxTick + 4'h1;
      unique case (rxState)
        ur_pkg::RX_IDLE: if (!rxS) begin
          rxState <= ur_pkg::RX_START;
          rxTick <= 4'h0;
        end
        ur_pkg::RX_START: if (baudTick && rxTick == ur_pkg::HALF_BIT) begin
          rxState <= rxS ? ur_pkg::RX_IDLE : ur_pkg::RX_DATA;
          rxTick <= 4'h0;
          rxBit <= 3'h0;
        end
        ur_pkg::RX_DATA: if (baudTick && rxTick == ur_pkg::FULL_BIT) begin
          rxShift <= {rxS, rxShift[7:1]};
          rxBit <= rxBit + 3'h1;
          if (rxBit == {1'b1, line_control[1:0]}) begin // RULE9
            rxState <= line_control[ur_pkg::PAR_EN_BIT] ? ur_pkg::RX_PARITY : ur_pkg::RX_STOP;
          end
        end
        ur_pkg::RX_PARITY: if (baudTick && rxTick == ur_pkg::FULL_BIT) begin
          rxParBit <= rxS;
          rxState <= ur_pkg::RX_STOP;
        end
        ur_pkg::RX_STOP: if (baudTick && rxTick == ur_pkg::FULL_BIT) begin
          rxPush <= 1'b1;
          rxState <= ur_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // the stop sample is still on the line when rxPush fires
  assign rxData = rxShift >> (2'd3 - line_control[1:0]);
  always_comb begin
    rxEntry.data = rxData;
    rxEntry.frameErr = !rxS;
    rxEntry.parErr = line_control[ur_pkg::PAR_EN_BIT]
      && (rxParBit != ((^rxData) ^ ~line_control[ur_pkg::PAR_EVEN_BIT]));
    rxEntry.brk = !rxS && rxData == 8'h00
      && (!line_control[ur_pkg::PAR_EN_BIT] || !rxParBit);
  end
  assign rxAccept = fifoEn ? rxInReady : rxCount == '0;
  assign rxPop = rdData && rxOutValid; // RULE2

  ur_fifo #(.WIDTH(11), .DEPTH(ur_pkg::FIFO_DEPTH)) rxFifo (
    .clk(clk), .rstn(rstn), .flush(rxFlush),
    .inValid(rxPush && rxAccept), .inReady(rxInReady), .inData(rxEntry),
    .outValid(rxOutValid), .outReady(rdData), .outData(rxHead),
    .count(rxCount)
  );

  // errored characters held in the fifo, for the summary flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      errCnt <= '0;
    end else if (rxFlush) begin
      errCnt <= '0;
    end else begin
      errCnt <= errCnt
        + CW'(rxPush && rxAccept && (rxEntry.parErr || rxEntry.frameErr || rxEntry.brk))
        - CW'(rxPop && (rxHead.parErr || rxHead.frameErr || rxHead.brk)); // RULE13
    end
  end

  // sticky line errors; a new event beats a clearing read
  assign newFlags = {rxPush && rxAccept && rxEntry.brk,
                     rxPush && rxAccept && rxEntry.frameErr,
                     rxPush && rxAccept && rxEntry.parErr,
                     rxPush && !rxAccept}; // RULE11
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lsrFlags <= 4'h0;
    end else begin
      lsrFlags <= (rdLsr ? 4'h0 : lsrFlags) | newFlags; // RULE20
    end
  end

  // modem input changes; ring records only its trailing edge
  always_comb begin
    next_msrDelta = rdMsr ? 4'h0 : msrDelta; // RULE20
    next_msrDelta[0] = next_msrDelta[0] | (msrLvl[0] ^ msrPrev[0]); // RULE14
    next_msrDelta[1] = next_msrDelta[1] | (msrLvl[1] ^ msrPrev[1]);
    next_msrDelta[2] = next_msrDelta[2] | (msrPrev[2] & ~msrLvl[2]);
    next_msrDelta[3] = next_msrDelta[3] | (msrLvl[3] ^ msrPrev[3]);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msrPrev <= 4'h0;
      msrDelta <= 4'h0;
    end else begin
      msrPrev <= msrLvl;
      msrDelta <= next_msrDelta;
    end
  end

  // receive trigger level
  always_comb begin
    unique case (trigSel)
      2'b00: trigLevel = ur_pkg::TRIG_1;
      2'b01: trigLevel = ur_pkg::TRIG_4;
      2'b10: trigLevel = ur_pkg::TRIG_8;
      2'b11: trigLevel = ur_pkg::TRIG_14;
    endcase
  end
  assign rxHit = fifoEn ? rxCount >= trigLevel : rxCount != '0; // RULE8

  // single request line from the four enabled sources
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= (ier[0] && rxHit) || (ier[1] && thrEmpty)
        || (ier[2] && lsrFlags != 4'h0) || (ier[3] && msrDelta != 4'h0); // RULE6
    end
  end

  // read data is registered; reads have side effects only on offsets 0,5,6
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rdEn) begin
      unique case (addr) // RULE17
        ur_pkg::OFF_DATA: rdata <= divisor_access_select ? divisor[7:0] : rxHead.data; // RULE2
        ur_pkg::OFF_IER: rdata <= divisor_access_select ? divisor[15:8] : ier; // RULE4
        ur_pkg::OFF_FCR: rdata <= {fifoEn, fifoEn, 5'h00, ~irq};
        ur_pkg::OFF_LCR: rdata <= line_control;
        ur_pkg::OFF_MCR: rdata <= modem_control;
        ur_pkg::OFF_LSR: rdata <= {errCnt != '0, tsrEmpty, thrEmpty,
                                   lsrFlags, rxCount != '0}; // RULE11
        ur_pkg::OFF_MSR: rdata <= {msrLvl, msrDelta}; // RULE15
        ur_pkg::OFF_SCR: rdata <= scratch;
      endcase
    end
  end

  sequence s_set_divisor_access_select;
    wrEn && addr == ur_pkg::OFF_LCR && wdata[7];
  endsequence
  sequence s_write_lo;
    wrEn && addr == ur_pkg::OFF_DATA;
  endsequence
  sequence s_write_scr;
    wrEn && addr == ur_pkg::OFF_SCR;
  endsequence
  sequence s_read_scr;
    rdEn && addr == ur_pkg::OFF_SCR;
  endsequence

  a_divisor_lo_write: assert property (s_set_divisor_access_select ##1 s_write_lo |=> // RULE4
    divisor[7:0] == $past(wdata)) else $error("divisor low byte not loaded");
  a_scratch_echo: assert property (s_write_scr ##1 s_read_scr |=> // RULE16
    rdata == $past(wdata, 2)) else $error("scratch byte did not read back");
  a_dtr_follow: assert property (wrEn && addr == ur_pkg::OFF_MCR |=> ##1 // RULE10
    dtrN == !$past(wdata[0], 2) && rtsN == !$past(wdata[1], 2))
    else $error("modem outputs do not follow control");
  a_thr_fill: assert property (wrData && txCount == '0 |=> !thrEmpty) // RULE12
    else $error("holding empty after data write");
  // a start bit spans hundreds of clocks; eight of them are enough to see it held low
  a_start_low: assert property (txPop |=> !txd [*8]) // RULE19
    else $error("start bit not low");
  a_rx_flush: assert property (rxFlush |=> rxCount == '0 && errCnt == '0) // RULE7
    else $error("receive fifo not flushed");
  a_msr_clear: assert property (rdMsr && msrLvl == msrPrev |=> msrDelta == 4'h0) // RULE20
    else $error("change bits not cleared by read");
  a_rx_ready: assert property (rxPush && rxAccept |=> rxCount != '0) // RULE11
    else $error("accepted character not counted");
  a_lsr_summary: assert property (rdLsr |=> rdata[7] == $past(errCnt != '0)) // RULE13
    else $error("error summary wrong");
  a_trig_level: assert property (fifoEn && trigSel == 2'b11 && ier[0]
    && rxCount == 5'h0E |=> irq) // RULE8
    else $error("trigger of 14 did not raise request");
endmodule : ur_uart

// file: bench/ur_remote.sv
`timescale 1ns/1ns

// behavioural far-end uart: records every frame the block sends and
// sends frames on request, with the stop level chosen by the caller
module ur_remote #(
  parameter int BIT_NS = 8681
) (
  input wire logic txd,
  output logic rxd,
  input wire logic [3:0] nBits
);
  logic [7:0] gotQ[$];
  logic [7:0] shiftIn;

  // the line idles at mark between frames
  initial rxd = 1'b1;

  // receive side: centre-sample each bit, one bit time apart
  always begin
    @(negedge txd);
    #(BIT_NS / 2);
    shiftIn = 8'h00;
    for (int i = 0; i < nBits; i++) begin
      #(BIT_NS);
      shiftIn[i] = txd;
    end
    #(BIT_NS);
    // a low stop bit is stored as unknown so no compare can pass on it
    if (txd === 1'b1) begin
      gotQ.push_back(shiftIn);
    end else begin
      gotQ.push_back(8'hxx);
    end
  end

  // send side: start, data lsb first, stop, then one idle bit
  task automatic send_char(input logic [7:0] data, input int bits, input logic stopLevel);
    rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < bits; i++) begin
      rxd = data[i];
      #(BIT_NS);
    end
    rxd = stopLevel;
    #(BIT_NS);
    rxd = 1'b1;
    #(BIT_NS);
  endtask : send_char
endmodule : ur_remote

// file: bench/ur_uart_tb.sv
`timescale 1ns/1ns

module ur_uart_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic txd;
  logic rxd;
  logic dtrN;
  logic rtsN;
  logic ctsN = 1'b1;
  logic dsrN = 1'b1;
  logic riN = 1'b1;
  logic dcdN = 1'b1;
  logic [3:0] nBits = 4'h8;
  int errCount = 0;
  int samplesChecked = 0;

  // 100 MHz
  always #5 clk = ~clk;

  ur_uart i_ur_uart (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wrEn(wrEn),
    .rdEn(rdEn), .rdata(rdata), .irq(irq), .txd(txd), .rxd(rxd), .ctsN(ctsN),
    .dsrN(dsrN), .riN(riN), .dcdN(dcdN), .dtrN(dtrN), .rtsN(rtsN));

  ur_remote i_ur_remote (.txd(txd), .rxd(rxd), .nBits(nBits));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, launched and dropped at falling edges
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wrEn = 1'b1;
    @(negedge clk);
    wrEn = 1'b0;
  endtask : wr

  // read data is registered, so it is settled by the next falling edge
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rdEn = 1'b1;
    @(negedge clk);
    rdEn = 1'b0;
    chk(rdata, exp);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // bounded wait for the far end to have collected n frames
  task automatic waitTx(input int n);
    for (int i = 0; i < 40000 && i_ur_remote.gotQ.size() < n; i++) begin
      @(negedge clk);
    end
  endtask : waitTx

  task automatic testDone;
    $display("errors %0d, comparisons %0d", errCount, samplesChecked);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : testDone

  // watchdog: the full sequence needs roughly 620 us
  initial begin
    #(2_000_000);
    errCount++;
    testDone();
  end

  initial begin
    idle(6);
    rstn = 1'b1;
    idle(2);
    chk({6'h00, dtrN, rtsN}, 8'h03);
    chk({7'h00, irq}, 8'h00);
    rdchk(ur_pkg::OFF_LSR, 8'h60);
    rdchk(ur_pkg::OFF_LCR, 8'h00);
    rdchk(ur_pkg::OFF_SCR, 8'h00);
    wr(ur_pkg::OFF_SCR, 8'h5A);
    rdchk(ur_pkg::OFF_SCR, 8'h5A);
    wr(ur_pkg::OFF_SCR, 8'hA5);
    rdchk(ur_pkg::OFF_SCR, 8'hA5);
    // divisor access, then fastest rate to keep frames short
    wr(ur_pkg::OFF_LCR, 8'h80);
    rdchk(ur_pkg::OFF_LCR, 8'h80);
    rdchk(ur_pkg::OFF_DATA, 8'h0C);
    rdchk(ur_pkg::OFF_IER, 8'h00);
    wr(ur_pkg::OFF_DATA, 8'h01);
    wr(ur_pkg::OFF_IER, 8'h00);
    rdchk(ur_pkg::OFF_DATA, 8'h01);
    wr(ur_pkg::OFF_LCR, 8'h03);
    rdchk(ur_pkg::OFF_LCR, 8'h03);
    wr(ur_pkg::OFF_IER, 8'h0F);
    rdchk(ur_pkg::OFF_IER, 8'h0F);
    idle(3);
    chk({7'h00, irq}, 8'h01);
    wr(ur_pkg::OFF_IER, 8'h00);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    // modem outputs are active low
    wr(ur_pkg::OFF_MCR, 8'h01);
    idle(2);
    chk({6'h00, dtrN, rtsN}, 8'h01);
    wr(ur_pkg::OFF_MCR, 8'h02);
    idle(2);
    chk({6'h00, dtrN, rtsN}, 8'h02);
    rdchk(ur_pkg::OFF_MCR, 8'h02);
    // modem inputs: clear stale deltas first
    rdchk(ur_pkg::OFF_MSR, 8'h00);
    ctsN = 1'b0;
    idle(6);
    rdchk(ur_pkg::OFF_MSR, 8'h11);
    rdchk(ur_pkg::OFF_MSR, 8'h10);
    dsrN = 1'b0;
    dcdN = 1'b0;
    idle(6);
    rdchk(ur_pkg::OFF_MSR, 8'hBA);
    riN = 1'b0;
    idle(6);
    rdchk(ur_pkg::OFF_MSR, 8'hF0);
    riN = 1'b1;
    idle(6);
    rdchk(ur_pkg::OFF_MSR, 8'hB4);
    wr(ur_pkg::OFF_IER, 8'h08);
    ctsN = 1'b1;
    idle(6);
    chk({7'h00, irq}, 8'h01);
    rdchk(ur_pkg::OFF_MSR, 8'hA1);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    wr(ur_pkg::OFF_IER, 8'h00);
    // transmit two back to back through the fifo
    wr(ur_pkg::OFF_FCR, 8'h01);
    wr(ur_pkg::OFF_DATA, 8'hA5);
    wr(ur_pkg::OFF_DATA, 8'h3C);
    rdchk(ur_pkg::OFF_LSR, 8'h00);
    waitTx(2);
    chk(i_ur_remote.gotQ[0], 8'hA5);
    chk(i_ur_remote.gotQ[1], 8'h3C);
    idle(600);
    rdchk(ur_pkg::OFF_LSR, 8'h60);
    // five-bit characters drop the upper bits
    nBits = 4'h5;
    wr(ur_pkg::OFF_LCR, 8'h00);
    wr(ur_pkg::OFF_DATA, 8'hF5);
    waitTx(3);
    chk(i_ur_remote.gotQ[2], 8'h15);
    idle(600);
    nBits = 4'h8;
    wr(ur_pkg::OFF_LCR, 8'h03);
    // transmit flush leaves only the character already shifting
    wr(ur_pkg::OFF_DATA, 8'h11);
    wr(ur_pkg::OFF_DATA, 8'h22);
    wr(ur_pkg::OFF_FCR, 8'h05);
    rdchk(ur_pkg::OFF_LSR, 8'h20);
    waitTx(4);
    chk(i_ur_remote.gotQ[3], 8'h11);
    idle(1200);
    chk(8'(i_ur_remote.gotQ.size()), 8'h04);
    // receive, read the oldest, then flush the rest
    i_ur_remote.send_char(8'h3C, 8, 1'b1);
    i_ur_remote.send_char(8'hC3, 8, 1'b1);
    idle(40);
    rdchk(ur_pkg::OFF_LSR, 8'h61);
    rdchk(ur_pkg::OFF_DATA, 8'h3C);
    wr(ur_pkg::OFF_FCR, 8'h03);
    rdchk(ur_pkg::OFF_LSR, 8'h60);
    // low stop bit: framing flag clears on read, fifo flag stays until popped
    i_ur_remote.send_char(8'h55, 8, 1'b0);
    idle(40);
    rdchk(ur_pkg::OFF_LSR, 8'hE9);
    rdchk(ur_pkg::OFF_LSR, 8'hE1);
    rdchk(ur_pkg::OFF_DATA, 8'h55);
    rdchk(ur_pkg::OFF_LSR, 8'h60);
    testDone();
  end
endmodule : ur_uart_tb
